// file: smd_pkg.sv
/*
  Shared constants and types for the servo monitor display block.
  Assumes a single 125 MHz system clock; all users import the whole package.
*/
package smd_pkg;

  // System clock and front-panel data key hold time
  localparam int unsigned CLK_HZ      = 125_000_000;
  localparam int unsigned HOLD_MS     = 1000;
  localparam int unsigned HOLD_CYCLES = CLK_HZ / 1000 * HOLD_MS;

  // Monitor list: 14 standard items, then internal items from 0x100
  localparam int unsigned STD_ITEMS    = 14;
  localparam logic [4:0]  IDX_LAST     = 5'h12;
  localparam logic [11:0] MON_INT_BASE = 12'h100;

  // Monitor numbers
  localparam logic [11:0] MON_SPEED_FB              = 12'h000;
  localparam logic [11:0] MON_SPEED_CMD             = 12'h001;
  localparam logic [11:0] MON_TORQUE_CMD            = 12'h002;
  localparam logic [11:0] INDEX_EDGE_POSITION_ITEM  = 12'h003;
  localparam logic [11:0] MON_ELEC_ANGLE            = 12'h004;
  localparam logic [11:0] INPUT_STATE_ITEM          = 12'h005;
  localparam logic [11:0] OUTPUT_STATE_ITEM         = 12'h006;
  localparam logic [11:0] MON_PULSE_SPEED           = 12'h007;
  localparam logic [11:0] POSITION_ERROR_ITEM       = 12'h008;
  localparam logic [11:0] CUMULATIVE_LOAD_ITEM      = 12'h009;
  localparam logic [11:0] MON_REGEN_LOAD            = 12'h00A;
  localparam logic [11:0] MON_BRAKE_LOAD            = 12'h00B;
  localparam logic [11:0] COMMAND_PULSE_COUNT_ITEM  = 12'h00C;
  localparam logic [11:0] FEEDBACK_PULSE_COUNT_ITEM = 12'h00D;
  localparam logic [11:0] MON_MODEL_GAIN            = 12'h103;
  localparam logic [11:0] MON_ENC_COMM_ERR          = 12'h104;

  // Display: five digits, segment bits {dp,g,f,e,d,c,b,a}, lit high
  localparam logic [4:0]   BLINK_NUM = 5'h07;
  localparam logic [7:0]   SEG_U     = 8'h3E;
  localparam logic [7:0]   SEG_N     = 8'h54;
  localparam logic [7:0]   SEG_H     = 8'h76;
  localparam logic [7:0]   SEG_L     = 8'h38;
  localparam logic [7:0]   SEG_DP    = 8'h80;
  localparam logic [7:0]   SEG_UP_R  = 8'h02;
  localparam logic [7:0]   SEG_LO_R  = 8'h04;
  localparam logic [7:0]   SEG_UP_L  = 8'h20;
  localparam logic [7:0]   SEG_LO_L  = 8'h10;
  localparam logic [127:0] SEG_HEX   = {8'h71, 8'h79, 8'h5E, 8'h39, 8'h7C, 8'h77, 8'h6F, 8'h7F,
                                        8'h07, 8'h7D, 8'h6D, 8'h66, 8'h4F, 8'h5B, 8'h06, 8'h3F};

  // Operating modes of the panel
  typedef enum logic [1:0] {ST_STATUS, ST_MON_NUM, ST_MON_VAL} smd_mode_e;

  // Whole state of the monitor display
  typedef struct packed {
    smd_mode_e   mode;
    logic [4:0]  sel;
    logic        low_half;
    logic [31:0] cnt_cmd;
    logic [31:0] cnt_fb;
    logic        up_q;
    logic        dn_q;
    logic        unit_q;
    logic        mode_key_q;
    logic [39:0] seg;
    logic [4:0]  blink;
    logic        monitor;
  } smd_state_s;

  localparam smd_state_s STATE_RESET = '0;

endpackage

// file: smd_hold_timer.sv
/*
  Hold timer for the front-panel data key: one pulse per press, once the key
  has stayed down for CYCLES clocks. Key level is synchronous to mclk.
*/
`timescale 1ns/1ps
module smd_hold_timer
  import smd_pkg::*;
#(
  parameter int unsigned CYCLES = HOLD_CYCLES
) (
  // Clock, reset, enable
  input  wire logic mclk,
  input  wire logic rst_n,
  input  wire logic ce,
  // Key level in, hold pulse out
  input  wire logic key,
  output wire logic fire
);

  localparam int unsigned W = $clog2(CYCLES + 1);
  localparam logic [W-1:0] CNT_LAST = W'(CYCLES - 1);

  typedef struct packed {
    logic [W-1:0] cnt;
    logic         done;
    logic         fire;
  } smd_hold_s;

  smd_hold_s st_q;
  smd_hold_s st_d;

  if (CYCLES < 1) begin : g_chk
    $error("smd_hold_timer: CYCLES must be at least 1");
  end

  // Release restarts the count, so a short tap never fires
  always_comb begin
    st_d      = st_q;
    st_d.fire = 1'b0;
    if (!key) begin
      st_d.cnt  = '0;
      st_d.done = 1'b0;
    end else if (!st_q.done) begin
      if (st_q.cnt == CNT_LAST) begin
        st_d.fire = 1'b1;
        st_d.done = 1'b1;
      end else begin
        st_d.cnt = st_q.cnt + W'(1);
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= '0;
    end else if (ce) begin
      st_q <= st_d;
    end
  end

  assign fire = st_q.fire;

  property p_hold_full;
    @(posedge mclk) disable iff (!rst_n)
    $rose(st_q.fire) |-> $past(key) && $past(ce) && $past(st_q.cnt) == CNT_LAST;
  endproperty
  a_hold_full: assert property (p_hold_full) else $error("hold pulse before full hold");

  property p_hold_restart;
    @(posedge mclk) disable iff (!rst_n)
    ce && !key |=> st_q.cnt == '0 && !st_q.fire;
  endproperty
  a_hold_restart: assert property (p_hold_restart) else $error("no restart on release");

endmodule

// file: smd_monitor_display.sv
/*
  Monitor mode of the servo drive front panel: key handling, monitor number
  selection, value rendering onto five seven-segment digits, and the two
  32-bit pulse counters. Keys, pins and monitored quantities are levels
  synchronous to mclk; the LED driver multiplexes and flashes digits.
*/
`timescale 1ns/1ps
module smd_monitor_display
  import smd_pkg::*;
#(
  parameter int unsigned HOLD_CYC = HOLD_CYCLES
) (
  // Clock, reset and clock enable
  input  wire logic        mclk,
  input  wire logic        rstn,
  input  wire logic        ce,
  // Operator keys, high while pressed
  input  wire logic        key_mode,
  input  wire logic        key_up,
  input  wire logic        key_down,
  input  wire logic        key_data_panel,
  input  wire logic        key_data_unit,
  // Status display pattern shown outside monitor mode
  input  wire logic [39:0] status_seg,
  // Monitored quantities, signed two's complement
  input  wire logic [15:0] speed_fb,
  input  wire logic [15:0] speed_cmd,
  input  wire logic [15:0] torque_cmd,
  input  wire logic [15:0] index_edge_pos,
  input  wire logic [15:0] elec_angle,
  input  wire logic [15:0] pulse_speed,
  input  wire logic [15:0] position_error,
  input  wire logic [15:0] cumulative_load,
  input  wire logic [15:0] regen_load,
  input  wire logic [15:0] brake_load,
  input  wire logic [15:0] model_gain,
  input  wire logic [15:0] enc_comm_errors,
  // Control pin levels, 1 = high level = off
  input  wire logic [7:0]  in_level,
  input  wire logic [6:0]  out_level,
  // Counter sources, one step per strobe
  input  wire logic        cmd_pulse_stb,
  input  wire logic        cmd_pulse_dn,
  input  wire logic        fb_edge_stb,
  input  wire logic        fb_edge_dn,
  // Display
  output wire logic [39:0] disp_seg_q,
  output wire logic [4:0]  disp_blink_q,
  output wire logic        monitor_mode_q
);

  if (HOLD_CYC < 1 || IDX_LAST != 5'(STD_ITEMS + 4)) begin : g_chk
    $error("smd_monitor_display: bad hold count or item list");
  end

  logic        rst_s1_q;
  logic        rst_q;
  smd_state_s  st_q;
  smd_state_s  st_d;
  logic        panel_fire;
  logic        data_fire;
  logic        mode_rise;
  logic        up_rise;
  logic        dn_rise;
  logic        both;
  logic [11:0] num;
  logic        is_cnt;
  logic        clr_cmd;
  logic        clr_fb;
  logic [15:0] val;
  logic [31:0] cnt_sel;
  logic [15:0] half;
  logic [39:0] seg_view;

  // Item index to displayed monitor number, internal ones after the standard
  function automatic logic [11:0] mon_num(input logic [4:0] idx);
    if (idx < 5'(STD_ITEMS)) begin
      return {7'h00, idx};
    end
    return MON_INT_BASE + {7'h00, idx - 5'(STD_ITEMS)};
  endfunction

  // One hex digit to segments
  function automatic logic [7:0] seg_hex(input logic [3:0] n);
    return SEG_HEX[{n, 3'b000} +: 8];
  endfunction

  // Four hex digits to segments
  function automatic logic [31:0] seg_hex4(input logic [15:0] v);
    return {seg_hex(v[15:12]), seg_hex(v[11:8]), seg_hex(v[7:4]), seg_hex(v[3:0])};
  endfunction

  // Binary to five BCD digits by shift-and-add-three
  function automatic logic [19:0] to_bcd(input logic [15:0] b);
    logic [35:0] s;
    s = {20'h00000, b};
    for (int i = 0; i < 16; i++) begin
      for (int d = 0; d < 5; d++) begin
        if (s[16 + 4 * d +: 4] > 4'h4) begin
          s[16 + 4 * d +: 4] = s[16 + 4 * d +: 4] + 4'h3;
        end
      end
      s = s << 1;
    end
    return s[35:16];
  endfunction

  // Signed decimal; six characters will not fit, so the sign is the leading dp
  function automatic logic [39:0] seg_dec5(input logic [15:0] v);
    logic        neg;
    logic [15:0] mag;
    logic [19:0] bcd;
    neg = v[15];
    mag = neg ? ~v + 16'h0001 : v;
    bcd = to_bcd(mag);
    return {seg_hex(bcd[19:16]) | (neg ? SEG_DP : 8'h00), seg_hex4(bcd[15:0])};
  endfunction

  // Segment pairs, indicator 1 rightmost; upper lit for high level
  function automatic logic [39:0] seg_pairs(input logic [7:0] lvl, input logic [7:0] used);
    logic [39:0] r;
    r = '0;
    for (int i = 0; i < 8; i++) begin
      if (used[i]) begin
        if (i % 2 == 0) begin
          r[(i / 2) * 8 +: 8] = r[(i / 2) * 8 +: 8] | (lvl[i] ? SEG_UP_R : SEG_LO_R);
        end else begin
          r[(i / 2) * 8 +: 8] = r[(i / 2) * 8 +: 8] | (lvl[i] ? SEG_UP_L : SEG_LO_L);
        end
      end
    end
    return r;
  endfunction

  // Counter step; a strobe in the clearing cycle still counts from zero
  function automatic logic [31:0] cnt_next(input logic [31:0] c, input logic clr,
                                           input logic stb, input logic dn);
    logic [31:0] b;
    b = clr ? 32'h0000_0000 : c;
    if (stb) begin
      b = dn ? b - 32'h0000_0001 : b + 32'h0000_0001;
    end
    return b;
  endfunction

  // Reset release through two flops
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rst_s1_q <= 1'b0;
      rst_q    <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_q    <= rst_s1_q;
    end
  end

  // Front-panel data key must stay down for the full hold time
  smd_hold_timer #(
    .CYCLES (HOLD_CYC)
  ) u_hold (
    .mclk  (mclk),
    .rst_n (rst_q),
    .ce    (ce),
    .key   (key_data_panel),
    .fire  (panel_fire)
  );

  // Key events; the hand-held unit acts on the press itself
  assign mode_rise = key_mode & ~st_q.mode_key_q;
  assign up_rise   = key_up & ~st_q.up_q;
  assign dn_rise   = key_down & ~st_q.dn_q;
  assign both      = key_up & key_down & (up_rise | dn_rise);
  assign data_fire = panel_fire | (key_data_unit & ~st_q.unit_q);
  assign num       = mon_num(st_q.sel);
  assign is_cnt    = num == COMMAND_PULSE_COUNT_ITEM || num == FEEDBACK_PULSE_COUNT_ITEM;
  assign clr_cmd   = st_q.mode == ST_MON_VAL && both && num == COMMAND_PULSE_COUNT_ITEM;
  assign clr_fb    = st_q.mode == ST_MON_VAL && both && num == FEEDBACK_PULSE_COUNT_ITEM;

  // Quantity behind each numeric item; scaling is done upstream
  always_comb begin
    case (num)
      MON_SPEED_FB:             val = speed_fb;
      MON_SPEED_CMD:            val = speed_cmd;
      MON_TORQUE_CMD:           val = torque_cmd;
      INDEX_EDGE_POSITION_ITEM: val = index_edge_pos;
      MON_ELEC_ANGLE:           val = elec_angle;
      MON_PULSE_SPEED:          val = pulse_speed;
      POSITION_ERROR_ITEM:      val = position_error;
      CUMULATIVE_LOAD_ITEM:     val = cumulative_load;
      MON_REGEN_LOAD:           val = regen_load;
      MON_BRAKE_LOAD:           val = brake_load;
      MON_MODEL_GAIN:           val = model_gain;
      MON_ENC_COMM_ERR:         val = enc_comm_errors;
      default:                  val = 16'h0000;
    endcase
  end

  // Digits to show, taken from the current state
  always_comb begin
    cnt_sel  = num == FEEDBACK_PULSE_COUNT_ITEM ? st_q.cnt_fb : st_q.cnt_cmd;
    half     = st_q.low_half ? cnt_sel[15:0] : cnt_sel[31:16];
    seg_view = status_seg;
    if (st_q.mode == ST_MON_NUM) begin
      seg_view = {SEG_U, SEG_N, seg_hex(num[11:8]), seg_hex(num[7:4]), seg_hex(num[3:0])};
    end else if (st_q.mode == ST_MON_VAL) begin
      if (num == INPUT_STATE_ITEM) begin
        // Bits: run, gain/dir/mode/lock/inhibit, fwd prohibit, rev prohibit,
        // alarm reset, fwd limit/speed 1, rev limit/speed 2, sensor on
        seg_view = seg_pairs(in_level, 8'hFF);
      end else if (num == OUTPUT_STATE_ITEM) begin
        // Bits: alarm, positioning/speed match, rotation, ready, code 1..3
        seg_view = seg_pairs({1'b0, out_level}, 8'h7F);
      end else if (is_cnt) begin
        seg_view = {(st_q.low_half ? SEG_L : SEG_H) | SEG_DP, seg_hex4(half)};
      end else begin
        seg_view = seg_dec5(val);
      end
    end
  end

  // Next state: modes, selection, counters and registered display
  always_comb begin
    st_d            = st_q;
    st_d.up_q       = key_up;
    st_d.dn_q       = key_down;
    st_d.unit_q     = key_data_unit;
    st_d.mode_key_q = key_mode;
    st_d.cnt_cmd    = cnt_next(st_q.cnt_cmd, clr_cmd, cmd_pulse_stb, cmd_pulse_dn);
    st_d.cnt_fb     = cnt_next(st_q.cnt_fb, clr_fb, fb_edge_stb, fb_edge_dn);
    unique case (st_q.mode)
      ST_STATUS: begin
        if (mode_rise) begin
          st_d.mode = ST_MON_NUM;
        end
      end
      ST_MON_NUM: begin
        if (mode_rise) begin
          st_d.mode = ST_STATUS;
        end else if (data_fire) begin
          st_d.mode     = ST_MON_VAL;
          st_d.low_half = 1'b0;
        end else if (both) begin
          st_d.sel = st_q.sel;
        end else if (up_rise) begin
          st_d.sel = st_q.sel == IDX_LAST ? 5'h00 : st_q.sel + 5'h01;
        end else if (dn_rise) begin
          st_d.sel = st_q.sel == 5'h00 ? IDX_LAST : st_q.sel - 5'h01;
        end
      end
      ST_MON_VAL: begin
        if (mode_rise) begin
          st_d.mode = ST_STATUS;
        end else if (data_fire) begin
          st_d.mode = ST_MON_NUM;
        end else if (is_cnt && !both && (up_rise || dn_rise)) begin
          st_d.low_half = ~st_q.low_half;
        end
      end
      default: begin
        st_d.mode = ST_STATUS;
      end
    endcase
    st_d.seg     = seg_view;
    st_d.blink   = st_d.mode == ST_MON_NUM ? BLINK_NUM : 5'h00;
    st_d.monitor = st_d.mode != ST_STATUS;
  end

  // Status display after power-on
  always_ff @(posedge mclk or negedge rst_q) begin
    if (!rst_q) begin
      st_q <= STATE_RESET;
    end else if (ce) begin
      st_q <= st_d;
    end
  end

  assign disp_seg_q     = st_q.seg;
  assign disp_blink_q   = st_q.blink;
  assign monitor_mode_q = st_q.monitor;

  default clocking cb @(posedge mclk);
  endclocking

  default disable iff (!rst_q);

  property p_boot_status;
    $rose(rst_q) |-> st_q.mode == ST_STATUS && !monitor_mode_q;
  endproperty
  a_boot_status: assert property (p_boot_status) else $error("not status after reset");

  property p_mode_enter;
    ce && st_q.mode == ST_STATUS && mode_rise |=> st_q.mode == ST_MON_NUM && monitor_mode_q;
  endproperty
  a_mode_enter: assert property (p_mode_enter) else $error("mode key not entered");

  property p_show_value;
    ce && st_q.mode == ST_MON_NUM && !mode_rise && data_fire |=> st_q.mode == ST_MON_VAL;
  endproperty
  a_show_value: assert property (p_show_value) else $error("value not shown");

  property p_back_number;
    ce && st_q.mode == ST_MON_VAL && !mode_rise && data_fire |=> st_q.mode == ST_MON_NUM;
  endproperty
  a_back_number: assert property (p_back_number) else $error("data key did not return");

  property p_step_up;
    ce && st_q.mode == ST_MON_NUM && !mode_rise && !data_fire && up_rise && !key_down
    |=> st_q.sel == ($past(st_q.sel) == IDX_LAST ? 5'h00 : $past(st_q.sel) + 5'h01);
  endproperty
  a_step_up: assert property (p_step_up) else $error("up key did not step number");

  property p_blink;
    disp_blink_q == ((st_q.mode == ST_MON_NUM) ? BLINK_NUM : 5'h00);
  endproperty
  a_blink: assert property (p_blink) else $error("flash mask does not follow mode");

  property p_clear;
    ce && clr_cmd |=> st_q.cnt_cmd == (!$past(cmd_pulse_stb) ? 32'h0000_0000 :
                                       $past(cmd_pulse_dn) ? 32'hFFFF_FFFF : 32'h0000_0001);
  endproperty
  a_clear: assert property (p_clear) else $error("counter not cleared");

  property p_count;
    ce && !clr_fb && fb_edge_stb && !fb_edge_dn |=> st_q.cnt_fb == $past(st_q.cnt_fb) + 32'h1;
  endproperty
  a_count: assert property (p_count) else $error("feedback edge not counted");

  property p_half_start;
    ce && st_q.mode == ST_MON_NUM && !mode_rise && data_fire |=> !st_q.low_half;
  endproperty
  a_half_start: assert property (p_half_start) else $error("opened on lower half");

  property p_input_pairs;
    ce && st_q.mode == ST_MON_VAL && num == INPUT_STATE_ITEM
    |=> disp_seg_q == seg_pairs($past(in_level), 8'hFF);
  endproperty
  a_input_pairs: assert property (p_input_pairs) else $error("input pairs wrong");

endmodule

// file: smd_panel_model.sv
/*
  Operator keypad model: drives the five key levels, high while pressed.
  Assumes it is called from one bench thread that runs on mclk.
*/
`timescale 1ns/1ps
module smd_panel_model (
  // Clock
  input  wire logic  mclk,
  // Key levels {panel data, unit data, down, up, mode}
  output logic [4:0] keys
);
  initial keys = 5'h00;

  // Hold keys for n sampled edges, then give the display time to settle
  task automatic press(input logic [4:0] m, input int n);
    @(posedge mclk) keys <= m;
    repeat (n) @(posedge mclk);
    keys <= 5'h00;
    repeat (3) @(negedge mclk);
  endtask
endmodule

// file: tb_servo_monitor_display.sv
/*
  Self-checking bench for the monitor display: walks every monitor number,
  values, segment pairs, both counters and the panel hold timing.
  Assumes the package is compiled first; hold time is shortened.
*/
`timescale 1ns/1ps
module tb_servo_monitor_display;
  import smd_pkg::*;
  localparam int unsigned HOLD = 8; // Short hold keeps the run brief
  logic        mclk   = 1'b0;
  logic        rstn   = 1'b0;
  logic        ce     = 1'b1;
  logic [4:0]  keys;
  logic [39:0] st_seg = 40'h0;
  logic [15:0] v [19] = '{default: 16'h0};
  logic [7:0]  in_lv  = 8'h00;
  logic [6:0]  out_lv = 7'h00;
  logic        cs = 1'b0, cd = 1'b0, fs = 1'b0, fd = 1'b0;
  wire  [39:0] seg;
  wire  [4:0]  blink;
  wire         mon;
  int          fails = 0, compares = 0, cyc = 0;
  int          cnt [2] = '{0, 0};

  always #4 mclk = ~mclk;

  smd_monitor_display #(.HOLD_CYC(HOLD)) u_dut (.mclk(mclk), .rstn(rstn), .ce(ce),
    .key_mode(keys[0]), .key_up(keys[1]), .key_down(keys[2]), .key_data_unit(keys[3]),
    .key_data_panel(keys[4]), .status_seg(st_seg), .speed_fb(v[0]), .speed_cmd(v[1]),
    .torque_cmd(v[2]), .index_edge_pos(v[3]), .elec_angle(v[4]), .pulse_speed(v[7]),
    .position_error(v[8]), .cumulative_load(v[9]), .regen_load(v[10]), .brake_load(v[11]),
    .model_gain(v[17]), .enc_comm_errors(v[18]), .in_level(in_lv), .out_level(out_lv),
    .cmd_pulse_stb(cs), .cmd_pulse_dn(cd), .fb_edge_stb(fs), .fb_edge_dn(fd),
    .disp_seg_q(seg), .disp_blink_q(blink), .monitor_mode_q(mon));
  smd_panel_model u_pnl (.mclk(mclk), .keys(keys));

  // Segment pattern helpers built from the rules
  function automatic logic [7:0] hd(int d);
    return SEG_HEX[d*8 +: 8];
  endfunction
  function automatic logic [39:0] num(int i);
    logic [11:0] n;
    n = (i < 14) ? 12'(i) : MON_INT_BASE + 12'(i - 14);
    return {SEG_U, SEG_N, hd(int'(n[11:8])), hd(int'(n[7:4])), hd(int'(n[3:0]))};
  endfunction
  function automatic logic [39:0] dec(logic [15:0] x);
    int          a;
    logic [39:0] r;
    a = $signed(x);
    if (a < 0) a = -a;
    for (int k = 0; k < 5; k++) begin
      r[k*8 +: 8] = hd(a % 10);
      a = a / 10;
    end
    r[39] = x[15]; // Sign shown as leftmost point
    return r;
  endfunction
  function automatic logic [39:0] pairs(logic [7:0] lv, int n);
    logic [39:0] r;
    r = 40'h0;
    for (int k = 0; k < n; k++) begin
      r[(k/2)*8 +: 8] |= (k % 2 == 0) ? (lv[k] ? SEG_UP_R : SEG_LO_R)
                                      : (lv[k] ? SEG_UP_L : SEG_LO_L);
    end
    return r;
  endfunction
  function automatic logic [31:0] hx4(logic [15:0] x);
    return {hd(int'(x[15:12])), hd(int'(x[11:8])), hd(int'(x[7:4])), hd(int'(x[3:0]))};
  endfunction
  function automatic logic [39:0] exp_val(int i);
    case (i)
      5:          return pairs(in_lv, 8);
      6:          return pairs({1'b0, out_lv}, 7);
      14, 15, 16: return dec(16'h0000);
      default:    return dec(v[i]);
    endcase
  endfunction

  task automatic chk(input string nm, input logic [39:0] seen, input logic [39:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic stop_test();
    if (fails == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // Cycle ceiling against a hang, far above the fewer than a thousand cycles used
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      stop_test();
    end
  end

  // Reference counters follow the strobes the design samples
  always @(posedge mclk) begin
    if (cs) cnt[0] = cnt[0] + (cd ? -1 : 1);
    if (fs) cnt[1] = cnt[1] + (fd ? -1 : 1);
  end

  // Main sequence
  initial begin
    void'($urandom(32'hFAC7));
    repeat (20) @(posedge mclk);
    rstn   <= 1'b1;
    st_seg <= {$urandom, 8'h5A};
    foreach (v[k]) v[k] <= 16'($urandom);
    in_lv  <= 8'($urandom);
    out_lv <= 7'($urandom);
    repeat (4) @(negedge mclk);
    chk("mode", mon, 1'b0);
    chk("status", seg, st_seg);
    u_pnl.press(5'h01, 1);
    chk("mode", mon, 1'b1);
    // Every number, its value except for the two pulse counters, and the wrap back to the first
    for (int i = 0; i < 20; i++) begin
      chk("number", seg, num(i % 19));
      chk("blink", blink, BLINK_NUM);
      if (i < 19 && i != 12 && i != 13) begin
        u_pnl.press(5'h08, 1);
        chk("value", seg, exp_val(i));
        chk("blink", blink, 5'h00);
        u_pnl.press(5'h08, 1);
        chk("back", seg, num(i));
      end
      u_pnl.press(5'h02, 1);
    end
    u_pnl.press(5'h04, 1);
    u_pnl.press(5'h04, 1);
    chk("number", seg, num(18));
    repeat (6) u_pnl.press(5'h04, 1);
    // Mostly downward strobes so the counts wrap below zero
    repeat (300) begin
      @(posedge mclk);
      cs <= 1'($urandom);
      cd <= ($urandom % 4) != 0;
      fs <= 1'($urandom);
      fd <= ($urandom % 4) != 0;
    end
    @(posedge mclk);
    cs <= 1'b0;
    fs <= 1'b0;
    for (int c = 0; c < 2; c++) begin
      u_pnl.press(5'h08, 1);
      chk("h_mark", seg[38:32], SEG_H[6:0]);
      chk("count_hi", seg[31:0], hx4(cnt[c][31:16]));
      u_pnl.press(5'h02, 1);
      chk("l_mark", seg[38:32], SEG_L[6:0]);
      chk("count_lo", seg[31:0], hx4(cnt[c][15:0]));
      u_pnl.press(5'h06, 1);
      cnt[c] = 0;
      chk("cleared", seg[31:0], hx4(16'h0000));
      u_pnl.press(5'h04, 1);
      chk("cleared_hi", seg[31:0], hx4(16'h0000));
      u_pnl.press(5'h08, 1);
      u_pnl.press(5'h02, 1);
    end
    // Panel key: one sample short of the hold, then a full hold
    u_pnl.press(5'h10, HOLD - 1);
    chk("short_hold", seg, num(14));
    u_pnl.press(5'h10, HOLD + 1);
    chk("held", seg, dec(16'h0000));
    u_pnl.press(5'h10, HOLD + 1);
    chk("held_back", seg, num(14));
    // Clock enable low: a key press must leave no trace
    @(posedge mclk);
    ce <= 1'b0;
    u_pnl.press(5'h02, 1);
    @(posedge mclk);
    ce <= 1'b1;
    repeat (3) @(negedge mclk);
    chk("frozen", seg, num(14));
    chk("frozen_blink", blink, BLINK_NUM);
    u_pnl.press(5'h01, 1);
    chk("status", seg, st_seg);
    stop_test();
  end
endmodule
